/* hdl/dma_ctrl.sv */
// Purpose: Control of a four-channel DMA engine: priority, start, reload, stop
// Assumes: APB slave at 25 MHz clk_sys; one bus word moved per read/write pair
// Notes:   Each rule below is tagged at the logic that keeps it
// Function
// - Fixed priority: channel 0 highest, channel 3 lowest.
// - Block mode keeps serving one channel until it ends.
// - Single-step re-arbitrates on bus release; higher channel wins.
// - Source, destination, count each have master and slave copies.
// - Terminal count reloads slaves from the latest master values.
// - Addresses and counting come from slave copies only.
// - Writes while idle update master and slave.
// - Writes during a transfer hit master only; slave reloads at end.
// - Reads during a transfer return the slave copy.
// - Terminal count and forced init both count as transfer end.
// - Software trigger starts when enable is 1 and flag is 0.
// - Selected peripheral interrupt starts transfer, even if masked.
// - NMI clears all enables; acknowledge waits for the bus cycle.
// - Terminal count sets the flag and pulses the end interrupt; read clears.
// - Writing 1 to init force-terminates the channel.
// - Restart register holds all enables; writing zero stops all.
`timescale 1ns/1ps
`default_nettype none
`include "dma_cfg.svh"

module dma_ctrl (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic [63:0]  periph_irq,
    input  wire logic         nmi,
    output logic              nmi_ack,
    output logic      [31:0]  bus_addr,
    output logic              bus_rd,
    output logic              bus_wr,
    output logic      [15:0]  bus_wdata,
    input  wire logic [15:0]  bus_rdata,
    input  wire logic         bus_ack,
    output dma_pkg::chan_t    active_channel,
    output logic      [3:0]   transfer_end_interrupt
);
    import dma_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////
    // Helpers
    // Lowest set bit wins
    function automatic chan_t pick(input logic [3:0] req);
        chan_t c;
        c = 2'h3;
        for (int i = 3; i >= 0; i--) begin
            if (req[i]) begin
                c = chan_t'(i);
            end
        end
        return c;
    endfunction : pick

    // Channel number to one-hot
    function automatic logic [3:0] onehot(input chan_t c);
        return 4'h1 << c;
    endfunction : onehot

    ctrl_t s;
    ctrl_t next_s;

    logic        done;
    logic        wr;
    logic        rd;
    chan_t       ch;
    logic [2:0]  idx;
    logic        is_chan;
    logic        is_rst;
    logic        mapped;
    logic [3:0]  step;
    logic [3:0]  term_hit;
    logic [3:0]  init_w;
    logic [3:0]  ends;
    logic [31:0] src [4];
    logic [31:0] dst [4];
    logic [15:0] cnt [4];
    logic [31:0] rd_val;

    ////////////////////////////////////////////////////////////////////////////////////
    // APB decode
    // Access completes in the first access cycle
    assign done    = psel && penable && s.pready;
    assign wr      = done && pwrite && mapped;
    assign rd      = done && !pwrite && mapped;
    assign ch      = paddr[6:5];
    assign idx     = paddr[4:2];
    assign is_chan = (paddr[11:7] == 5'h00) && (idx <= `DMA_REG_TSEL);
    assign is_rst  = (paddr == `DMA_RESTART_OFF);
    assign mapped  = is_chan || is_rst;

    // Per-channel strobes
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            step[g]     = (s.st == ST_WRITE) && bus_ack && s.inx[g] && (s.cur == chan_t'(g));
            term_hit[g] = step[g] && (cnt[g] == 16'h1);
            init_w[g]   = wr && is_chan && (ch == chan_t'(g)) && (idx == `DMA_REG_CTRL)
                          && pwdata[`DMA_CTRL_INIT];
        end
        ends = term_hit | init_w;
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Address and count buffers
    for (genvar g = 0; g < 4; g++) begin : g_buf
        dma_chan_buf u_buf (
            .clk_sys (clk_sys),
            .rst     (rst),
            .wr_en   (wr && is_chan && (ch == chan_t'(g)) && (idx <= `DMA_REG_COUNT)),
            .wr_idx  (idx),
            .wdata   (pwdata[15:0]),
            .busy    (s.inx[g]),
            .reload  (ends[g]),
            .step    (step[g]),
            .src     (src[g]),
            .dst     (dst[g]),
            .cnt     (cnt[g])
        );
    end

    // Read mux: buffers always show the slave copy
    always_comb begin
        rd_val = 32'h0;
        if (is_rst) begin
            rd_val[3:0] = s.en;
        end else begin
            case (idx)
                `DMA_REG_SRC_HI: rd_val[15:0] = src[ch][31:16];
                `DMA_REG_SRC_LO: rd_val[15:0] = src[ch][15:0];
                `DMA_REG_DST_HI: rd_val[15:0] = dst[ch][31:16];
                `DMA_REG_DST_LO: rd_val[15:0] = dst[ch][15:0];
                `DMA_REG_COUNT:  rd_val[15:0] = cnt[ch];
                `DMA_REG_CTRL: begin
                    rd_val[`DMA_CTRL_EN] = s.en[ch];
                    rd_val[`DMA_CTRL_TC] = s.term[ch];
                    rd_val[`DMA_CTRL_MODE_HI:`DMA_CTRL_MODE_LO] = s.mode[ch];
                end
                `DMA_REG_TSEL:   rd_val[5:0] = s.tsel[ch];
                default:         rd_val = 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_s         = s;
        next_s.end_irq = 4'h0;
        next_s.nmi_ack = 1'b0;
        // Register answer prepared in the setup cycle
        next_s.pready  = psel && !penable;
        if (psel && !penable) begin
            next_s.prdata  = mapped ? rd_val : 32'h0;
            next_s.pslverr = !mapped;
        end
        // Flag clears only if the read actually showed it set
        if (rd && is_chan && (idx == `DMA_REG_CTRL) && s.prdata[`DMA_CTRL_TC]) begin
            next_s.term[ch] = 1'b0;
        end
        // Register writes
        if (wr && is_rst) begin
            next_s.en = pwdata[3:0];
        end
        if (wr && is_chan && (idx == `DMA_REG_TSEL)) begin
            next_s.tsel[ch] = pwdata[5:0];
        end
        if (wr && is_chan && (idx == `DMA_REG_CTRL)) begin
            next_s.en[ch]   = pwdata[`DMA_CTRL_EN];
            next_s.mode[ch] = pwdata[`DMA_CTRL_MODE_HI:`DMA_CTRL_MODE_LO];
            if (pwdata[`DMA_CTRL_STG] && s.en[ch] && !s.term[ch]) begin
                next_s.pend[ch] = 1'b1;
                next_s.inx[ch]  = 1'b1;
            end
        end
        // Peripheral starts ignore the interrupt mask
        for (int i = 0; i < 4; i++) begin
            if (s.en[i] && !s.term[i] && periph_irq[s.tsel[i]]) begin
                next_s.pend[i] = 1'b1;
                next_s.inx[i]  = 1'b1;
            end
        end
        // Transfer engine
        case (s.st)
            ST_IDLE: begin
                if (s.nmi_pend) begin
                    next_s.nmi_pend = 1'b0;
                    next_s.nmi_ack  = 1'b1;
                end else if (|(s.pend & s.en)) begin
                    next_s.cur       = pick(s.pend & s.en);
                    next_s.pend[next_s.cur] = 1'b0;
                    next_s.st        = ST_READ;
                    next_s.bus_rd    = 1'b1;
                    next_s.bus_addr  = src[next_s.cur];
                end
            end
            ST_READ: begin
                if (bus_ack) begin
                    next_s.bus_rd    = 1'b0;
                    next_s.bus_wdata = bus_rdata;
                    next_s.st        = s.inx[s.cur] ? ST_GAP : ST_RELEASE;
                end
            end
            ST_GAP: begin
                if (s.inx[s.cur]) begin
                    next_s.st       = ST_WRITE;
                    next_s.bus_wr   = 1'b1;
                    next_s.bus_addr = dst[s.cur];
                end else begin
                    next_s.st = ST_RELEASE;
                end
            end
            ST_WRITE: begin
                if (bus_ack) begin
                    next_s.bus_wr = 1'b0;
                    next_s.st     = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if ((s.mode[s.cur] == `DMA_MODE_BLOCK) && s.inx[s.cur] && s.en[s.cur]
                    && !s.nmi_pend) begin
                    next_s.st       = ST_READ;
                    next_s.bus_rd   = 1'b1;
                    next_s.bus_addr = src[s.cur];
                end else begin
                    next_s.st = ST_IDLE;
                end
            end
            default: begin
                next_s.st     = ST_IDLE;
                next_s.bus_rd = 1'b0;
                next_s.bus_wr = 1'b0;
            end
        endcase
        // End of transfer: terminal count or forced init
        for (int i = 0; i < 4; i++) begin
            if (ends[i]) begin
                next_s.pend[i] = 1'b0;
                next_s.inx[i]  = 1'b0;
            end
            if (term_hit[i]) begin
                next_s.term[i]    = 1'b1;
                next_s.end_irq[i] = 1'b1;
            end
        end
        // NMI stops every channel; the bus cycle under way still completes
        if (nmi) begin
            next_s.en       = 4'h0;
            next_s.nmi_pend = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '{st: ST_IDLE, tsel: {4{`DMA_TSEL_RESET}}, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign prdata                 = s.prdata;
    assign pready                 = s.pready;
    assign pslverr                = s.pslverr;
    assign nmi_ack                = s.nmi_ack;
    assign bus_addr               = s.bus_addr;
    assign bus_rd                 = s.bus_rd;
    assign bus_wr                 = s.bus_wr;
    assign bus_wdata              = s.bus_wdata;
    assign active_channel         = s.cur;
    assign transfer_end_interrupt = s.end_irq;

    ////////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_fixed_prio: assert property (
        (s.st == ST_IDLE && !s.nmi_pend && |(s.pend & s.en))
        |=> s.st == ST_READ && (($past(s.pend & s.en) & (onehot(s.cur) - 4'h1)) == 4'h0))
        else $error("lower channel granted over a higher pending one");
    a_block_hold: assert property (
        (s.st == ST_RELEASE && s.mode[s.cur] == `DMA_MODE_BLOCK && s.inx[s.cur]
         && s.en[s.cur] && !s.nmi_pend)
        |=> s.st == ST_READ && s.cur == $past(s.cur))
        else $error("block transfer left its channel");
    a_step_rearb: assert property (
        (s.st == ST_RELEASE && s.mode[s.cur] != `DMA_MODE_BLOCK) |=> s.st == ST_IDLE)
        else $error("bus not released for arbitration");
    a_count_step: assert property (
        (s.st == ST_WRITE && bus_ack && s.inx[s.cur] && !ends[s.cur])
        |=> cnt[$past(s.cur)] == $past(cnt[s.cur]) - 16'h1)
        else $error("count did not step on write");
    // An init or terminal count in the same cycle ends the transfer at once
    a_sw_start: assert property (
        (wr && is_chan && idx == `DMA_REG_CTRL && pwdata[`DMA_CTRL_STG] && s.en[ch]
         && !s.term[ch] && !ends[ch] && !nmi)
        |=> s.inx[$past(ch)])
        else $error("software trigger did not start");
    // A slow bus may stretch the unfinished read and write to about fifty cycles
    a_nmi_stop: assert property (
        nmi |=> s.en == 4'h0 ##[1:100] s.nmi_ack)
        else $error("nmi did not stop channels or acknowledge");
    a_nmi_idle: assert property (
        s.nmi_ack |-> $past(s.st) == ST_IDLE && !bus_rd && !bus_wr)
        else $error("nmi acknowledged during a bus cycle");
    a_term_flag: assert property (
        |term_hit |=> ((s.term & $past(term_hit)) == $past(term_hit))
                      && transfer_end_interrupt == $past(term_hit)
                      ##1 transfer_end_interrupt == 4'h0)
        else $error("end flag or end interrupt wrong");
    a_init_stop: assert property (
        |init_w |=> (s.inx & $past(init_w)) == 4'h0)
        else $error("init did not end the transfer");
    a_apb_answer: assert property (
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

endmodule : dma_ctrl
`default_nettype wire

/* hdl/dma_cfg.svh */
// Purpose: Offsets, field positions, reset values and encodings of the DMA control block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH

// Channel n register block at n * 0x20, restart register above them
`define DMA_REG_SRC_HI    3'h0
`define DMA_REG_SRC_LO    3'h1
`define DMA_REG_DST_HI    3'h2
`define DMA_REG_DST_LO    3'h3
`define DMA_REG_COUNT     3'h4
`define DMA_REG_CTRL      3'h5
`define DMA_REG_TSEL      3'h6
`define DMA_RESTART_OFF   12'h080

// channel_control fields
`define DMA_CTRL_EN       0
`define DMA_CTRL_STG      1
`define DMA_CTRL_INIT     2
`define DMA_CTRL_TC       3
`define DMA_CTRL_MODE_LO  4
`define DMA_CTRL_MODE_HI  5

// Transfer modes
`define DMA_MODE_SINGLE   2'h0
`define DMA_MODE_STEP     2'h1
`define DMA_MODE_BLOCK    2'h2

// Reset values
`define DMA_REG_RESET     16'h0000
`define DMA_TSEL_RESET    6'h00

`endif

/* hdl/dma_pkg.sv */
// Purpose: Types shared by the DMA control block
// Assumes: Constants come from dma_cfg.svh
// Notes:   Transfer states are Gray coded along READ-GAP-WRITE-RELEASE
package dma_pkg;

    typedef logic [1:0] chan_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_READ    = 3'b001,
        ST_GAP     = 3'b011,
        ST_WRITE   = 3'b010,
        ST_RELEASE = 3'b110
    } xfer_state_t;

    typedef struct packed {
        xfer_state_t      st;
        chan_t            cur;
        logic [3:0]       pend;
        logic [3:0]       inx;
        logic [3:0]       en;
        logic [3:0]       term;
        logic [3:0]       end_irq;
        logic [3:0][1:0]  mode;
        logic [3:0][5:0]  tsel;
        logic             nmi_pend;
        logic             nmi_ack;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
        logic [31:0]      bus_addr;
        logic             bus_rd;
        logic             bus_wr;
        logic [15:0]      bus_wdata;
    } ctrl_t;

    typedef struct packed {
        logic [4:0][15:0] mst;
        logic [4:0][15:0] slv;
    } buf_t;

endpackage : dma_pkg

/* hdl/dma_chan_buf.sv */
// Purpose: Two-deep master/slave copies of one channel's addresses and count
// Assumes: wr_idx is 0..4 whenever wr_en is high
// Notes:   Transfers run from the slave copy only
`timescale 1ns/1ps
`default_nettype none
`include "dma_cfg.svh"

module dma_chan_buf (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_idx,
    input  wire logic [15:0] wdata,
    input  wire logic        busy,
    input  wire logic        reload,
    input  wire logic        step,
    output logic      [31:0] src,
    output logic      [31:0] dst,
    output logic      [15:0] cnt
);
    import dma_pkg::*;

    buf_t s;
    buf_t next_s;

    // Slave copy drives the transfer and the read-back
    assign src = {s.slv[0], s.slv[1]};
    assign dst = {s.slv[2], s.slv[3]};
    assign cnt = s.slv[4];

    // Master takes every write; slave only while idle, or by reload at the end
    always_comb begin
        next_s = s;
        if (wr_en) begin
            next_s.mst[wr_idx] = wdata;
        end
        if (reload) begin
            next_s.slv = next_s.mst;
        end else begin
            if (step) begin
                {next_s.slv[0], next_s.slv[1]} = src + 32'h1;
                {next_s.slv[2], next_s.slv[3]} = dst + 32'h1;
                next_s.slv[4] = cnt - 16'h1;
            end
            if (wr_en && !busy) begin
                next_s.slv[wr_idx] = wdata;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= {10{`DMA_REG_RESET}};
        end else begin
            s <= next_s;
        end
    end

endmodule : dma_chan_buf
`default_nettype wire

/* verification/dma_bus_model.sv */
// Purpose: System bus slave answering the engine's read and write cycles
// Assumes: One 16-bit word per cycle; ack is a one-cycle pulse
// Notes:   slow stretches each answer to 20 cycles
`timescale 1ns/1ps
`default_nettype none

module dma_bus_model (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        slow,
    input  wire logic        bus_rd,
    input  wire logic        bus_wr,
    input  wire logic [31:0] bus_addr,
    input  wire logic [15:0] bus_wdata,
    output logic      [15:0] bus_rdata,
    output logic             bus_ack,
    output int               nwr,
    output logic      [31:0] ra,
    output logic      [31:0] wa,
    output logic      [15:0] rdv,
    output logic      [15:0] wdv
);
    int          dly;
    int          lim;
    logic [15:0] v;

    // Answer a held cycle after a wait; data line churns outside the answer
    always @(posedge clk_sys) begin
        bus_ack <= 1'b0;
        bus_rdata <= ~bus_rdata;
        if (rst) begin
            dly <= 0;
            lim <= 0;
            nwr <= 0;
            bus_rdata <= 16'h0000;
        end else if ((bus_rd || bus_wr) && !bus_ack) begin
            if (dly >= (slow ? 20 : lim)) begin
                v = 16'($urandom);
                bus_ack <= 1'b1;
                dly <= 0;
                lim <= $urandom % 3;
                if (bus_rd) begin
                    bus_rdata <= v;
                    ra <= bus_addr;
                    rdv <= v;
                end else begin
                    wa <= bus_addr;
                    wdv <= bus_wdata;
                    nwr <= nwr + 1;
                end
            end else begin
                dly <= dly + 1;
            end
        end
    end
endmodule : dma_bus_model
`default_nettype wire

/* verification/test_four_channel_dma_control.sv */
// Purpose: Self-checking bench for the DMA control block
// Assumes: APB answers in the first access cycle
// Notes:   Count model keeps master and slave copies per channel
`timescale 1ns/1ps
`default_nettype none
`include "dma_cfg.svh"

module test_four_channel_dma_control;
    import dma_pkg::*;
    logic        clk_sys, rst, psel, penable, pwrite, nmi, slow, ev;
    logic        pready, pslverr, nmi_ack, bus_rd, bus_wr, bus_ack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, bus_addr, ra, wa, rv;
    logic [63:0] periph_irq;
    logic [15:0] bus_wdata, bus_rdata, rdv, wdv;
    logic [3:0]  transfer_end_interrupt;
    chan_t       active_channel;
    logic [31:0] src[4], dst[4];
    int          nwr, err_count, compares, k;
    int          ends[4], e0[4], b[4], mst[4], slv[4];
    bit          busy[4];

    dma_ctrl DUT (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .periph_irq, .nmi, .nmi_ack, .bus_addr, .bus_rd, .bus_wr,
        .bus_wdata, .bus_rdata, .bus_ack, .active_channel, .transfer_end_interrupt);
    dma_bus_model BUS (.clk_sys, .rst, .slow, .bus_rd, .bus_wr, .bus_addr, .bus_wdata,
        .bus_rdata, .bus_ack, .nwr, .ra, .wa, .rdv, .wdv);

    // Clock and end-of-transfer pulse counting
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        for (int i = 0; i < 4; i++) begin
            if (transfer_end_interrupt[i] === 1'b1) ends[i]++;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("errors=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // One APB transfer; result left in rv and ev
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk(0, 1);
            close_out();
        end
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rv, e);
    endtask : rd

    function automatic logic [11:0] ad(input int ch, input logic [2:0] idx);
        return 12'(ch * 32 + idx * 4);
    endfunction : ad

    // Count write goes to master, and to slave while the channel is idle
    task wcnt(input int ch, input int c);
        apb(1'b1, ad(ch, `DMA_REG_COUNT), 32'(c));
        mst[ch] = c;
        if (!busy[ch]) slv[ch] = c;
    endtask : wcnt

    // Bounded wait: -1 read cycle, -2 NMI ack, else write total
    task wt(input int n);
        for (k = 0; k < 3000; k++) begin
            @(posedge clk_sys);
            if (n == -1 ? bus_rd === 1'b1 : n == -2 ? nmi_ack === 1'b1 : nwr >= n) break;
        end
        if (k >= 3000) begin
            chk(0, 1);
            close_out();
        end
    endtask : wt

    task start(input int ch, input logic [31:0] ctl);
        b[ch] = nwr;
        e0[ch] = ends[ch];
        busy[ch] = 1;
        if (ctl != 0) apb(1'b1, ad(ch, `DMA_REG_CTRL), ctl);
    endtask : start

    task done(input int ch, input int tot);
        wt(tot);
        repeat (3) @(posedge clk_sys);
        busy[ch] = 0;
        slv[ch] = mst[ch];
        chk(ends[ch] - e0[ch], 1);
        rd(ad(ch, `DMA_REG_COUNT), slv[ch]);
        apb(1'b0, ad(ch, `DMA_REG_CTRL), 32'h0);
        chk(rv[3], 1);
        apb(1'b0, ad(ch, `DMA_REG_CTRL), 32'h0);
        chk(rv[3], 0);
    endtask : done

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {clk_sys, psel, penable, pwrite, nmi, slow} = '0;
        {paddr, pwdata, periph_irq} = '0;
        rst = 1'b1;
        void'($urandom(32'h2e0faf29));
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        // Reset values and an unmapped place
        rd(ad(2, `DMA_REG_CTRL), 0);
        rd(12'h080, 0);
        rd(12'h0a0, 0);
        chk(ev, 1);
        // Idle writes reach both copies; trigger while disabled does nothing
        src[0] = $urandom;
        dst[0] = $urandom;
        apb(1'b1, ad(0, `DMA_REG_SRC_HI), src[0][31:16]);
        apb(1'b1, ad(0, `DMA_REG_SRC_LO), src[0][15:0]);
        apb(1'b1, ad(0, `DMA_REG_DST_HI), dst[0][31:16]);
        apb(1'b1, ad(0, `DMA_REG_DST_LO), dst[0][15:0]);
        wcnt(0, 2);
        rd(ad(0, `DMA_REG_COUNT), 2);
        apb(1'b1, ad(0, `DMA_REG_CTRL), 32'h2);
        repeat (30) @(posedge clk_sys);
        chk(nwr, 0);
        apb(1'b1, ad(0, `DMA_REG_CTRL), 32'h1);
        // One software trigger per block; block mode moves both words on one request
        start(0, 32'h23);
        done(0, 2);
        chk(ra, src[0] + 1);
        chk(wa, dst[0] + 1);
        chk(wdv, rdv);
        // Write during a slow transfer: master only, reads show slave
        slow <= 1'b1;
        wcnt(0, 3);
        start(0, 32'h23);
        wt(-1);
        wcnt(0, 5);
        rd(ad(0, `DMA_REG_COUNT), 3);
        done(0, b[0] + 3);
        slow <= 1'b0;
        // Two peripheral requests in one cycle: channel 1 beats channel 3
        apb(1'b1, ad(1, `DMA_REG_TSEL), 32'h5);
        apb(1'b1, ad(3, `DMA_REG_TSEL), 32'h9);
        wcnt(1, 1);
        wcnt(3, 1);
        apb(1'b1, ad(1, `DMA_REG_CTRL), 32'h1);
        apb(1'b1, ad(3, `DMA_REG_CTRL), 32'h1);
        start(1, 0);
        start(3, 0);
        periph_irq <= 64'h220;
        @(posedge clk_sys);
        periph_irq <= 64'h0;
        wt(-1);
        chk(active_channel, 1);
        done(1, b[1] + 2);
        done(3, b[3] + 2);
        // Block mode channel 2 keeps the bus against channel 0
        wcnt(2, 3);
        apb(1'b1, ad(2, `DMA_REG_CTRL), 32'h21);
        apb(1'b1, ad(0, `DMA_REG_TSEL), 32'h7);
        wcnt(0, 1);
        start(0, 0);
        start(2, 32'h23);
        wt(-1);
        periph_irq <= 64'h80;
        @(posedge clk_sys);
        periph_irq <= 64'h0;
        for (int i = 0; i < 500 && nwr < b[2] + 3; i++) begin
            @(posedge clk_sys);
            chk(active_channel, 2);
        end
        done(2, b[2] + 3);
        done(0, b[2] + 4);
        // NMI halts the engine; init then reloads the count
        slow <= 1'b1;
        wcnt(0, 4);
        start(0, 32'h13);
        wt(-1);
        nmi <= 1'b1;
        @(posedge clk_sys);
        nmi <= 1'b0;
        wt(-2);
        rd(12'h080, 0);
        apb(1'b1, ad(0, `DMA_REG_CTRL), 32'h4);
        busy[0] = 0;
        slv[0] = mst[0];
        rd(ad(0, `DMA_REG_COUNT), slv[0]);
        chk(ends[0] - e0[0], 0);
        slow <= 1'b0;
        // Restart register sets and clears enables
        apb(1'b1, 12'h080, 32'h5);
        rd(12'h080, 32'h5);
        apb(1'b0, ad(2, `DMA_REG_CTRL), 32'h0);
        chk(rv[0], 1);
        apb(1'b1, 12'h080, 32'h0);
        apb(1'b1, 12'h080, 32'h0);
        rd(12'h080, 0);
        close_out();
    end
endmodule : test_four_channel_dma_control
`default_nettype wire
